// file: src/data_space_access.sv
`timescale 1ns/1ps
// Function
// - 16-bit data path, byte addressed words
// - Byte read selects lane, returns low
// - Byte write strobes matching lane only
// - Y path fetches words only
// - Post-increment steps 1 byte, 2 word
// - Odd word access raises address error
// - Misaligned read completes, write suppressed
// - Byte load changes low register byte
// - Near direct field reaches 0x0000-0x1FFF
// - Move direct field reaches full space
// - Stack grows up, push post-increments
// - Call push clears upper high byte
// - Exception push inserts status low byte
// - Limit not reset, bit 0 zero
// - Push beyond limit raises stack error
// - Stack address below 0x0800 traps
// - 16-bit byte effective address, 64 Kbytes
// - Unimplemented address reads as zero
module data_space_access
  import dsa_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // X access request
  input wire logic i_x_valid,
  input wire logic i_x_write,
  input wire logic i_x_byte,
  input wire amode_type i_x_mode,
  input wire logic [12:0] i_x_near_addr,
  input wire logic [15:0] i_x_far_addr,
  input wire logic [3:0] i_x_ptr_sel,
  input wire logic [15:0] i_x_wdata,
  input wire push_type i_push_kind,
  input wire logic [7:0] i_status_low,
  input wire logic i_dst_en,
  input wire logic [3:0] i_dst_sel,
  // X answer
  output logic o_x_rvalid,
  output logic [15:0] o_x_rdata,
  output logic [15:0] o_x_ea,
  output logic o_x_wr_done,
  // Y word fetch
  input wire logic i_y_valid,
  input wire logic [15:0] i_y_addr,
  output logic o_y_rvalid,
  output logic [15:0] o_y_rdata,
  // Trap requests
  input wire logic i_addr_err_ack,
  input wire logic i_stack_err_ack,
  output logic o_addr_err_req,
  output logic o_stack_err_req
);

  // ****************************************
  // Storage
  // ****************************************
  logic [15:0] wreg [16];
  logic [15:0] stack_limit_reg;
  logic [15:0] ram [RAM_WORDS];

  // ****************************************
  // Effective address
  // ****************************************
  logic [15:0] effective_address;
  logic [15:0] ptr_val;
  logic [15:0] step;
  logic is_push;
  logic is_pop;
  logic sp_use;
  logic misalign;
  logic stack_err;
  logic access_byte;

  assign is_push = (i_x_mode == MODE_PUSH);
  assign is_pop = (i_x_mode == MODE_POP);
  // Stack traffic is always whole words
  assign access_byte = i_x_byte && !is_push && !is_pop;
  assign ptr_val = wreg[i_x_ptr_sel];
  assign step = access_byte ? BYTE_STEP : WORD_STEP;

  always_comb
  begin
    case (i_x_mode)
      MODE_NEAR: effective_address = {3'b000, i_x_near_addr};
      MODE_FAR: effective_address = i_x_far_addr;
      MODE_IND: effective_address = ptr_val;
      MODE_IND_POST: effective_address = ptr_val;
      MODE_PUSH: effective_address = wreg[STACK_PTR_IDX];
      MODE_POP: effective_address = wreg[STACK_PTR_IDX] - WORD_STEP;
      default: effective_address = ptr_val;
    endcase
  end

  assign misalign = !access_byte && effective_address[0];

  // Any pointer access through the stack pointer is checked as well
  assign sp_use = is_push || is_pop
    || (((i_x_mode == MODE_IND) || (i_x_mode == MODE_IND_POST))
    && (i_x_ptr_sel == STACK_PTR_IDX));

  stack_check u_stack_check (
    .i_sp_use(sp_use),
    .i_push(is_push),
    .i_ea(effective_address),
    .i_limit(stack_limit_reg),
    .o_err(stack_err)
  );

  // ****************************************
  // Read source selection
  // ****************************************
  logic [4:0] reg_sel;
  logic reg_hit;
  logic lim_hit;
  logic mem_hit;
  logic [15:0] src_word;

  assign reg_sel = reg_decode(effective_address);
  assign reg_hit = reg_sel[4];
  // Decoded on the word so either byte of the limit can be reached
  assign lim_hit = ({effective_address[15:1], 1'b0} == STACK_LIM_ADDR);
  assign mem_hit = ram_hit(effective_address);

  always_comb
  begin
    if (reg_hit)
      src_word = wreg[reg_sel[3:0]];
    else if (lim_hit)
      src_word = stack_limit_reg;
    else if (mem_hit)
      src_word = ram[ram_index(effective_address)];
    else
      src_word = 16'h0000;
  end

  // ****************************************
  // Lane steering
  // ****************************************
  logic [15:0] push_data;
  logic [15:0] lane_rdata;
  logic [15:0] lane_wword;
  logic [1:0] lane_strobe;
  logic do_write;
  logic do_read;

  always_comb
  begin
    case (i_push_kind)
      PUSH_CALL_HI: push_data = {8'h00, i_x_wdata[7:0]};
      PUSH_EXC_HI: push_data = {i_status_low, i_x_wdata[7:0]};
      default: push_data = i_x_wdata;
    endcase
  end

  lane_steer u_lane_steer (
    .i_byte(access_byte),
    .i_ea_lsb(effective_address[0]),
    .i_word(src_word),
    .i_wdata(is_push ? push_data : i_x_wdata),
    .o_rdata(lane_rdata),
    .o_wword(lane_wword),
    .o_strobe(lane_strobe)
  );

  // ****************************************
  // Access direction
  // ****************************************
  logic dir_write;

  // Push always stores and pop always loads, whatever the write flag says
  always_comb
  begin
    if (is_push)
      dir_write = 1'b1;
    else if (is_pop)
      dir_write = 1'b0;
    else
      dir_write = i_x_write;
  end

  // A misaligned write runs the instruction but never reaches storage
  assign do_write = i_x_valid && dir_write && !misalign;
  // A misaligned read still returns data and completes
  assign do_read = i_x_valid && !dir_write;

  // ****************************************
  // Working registers and stack pointer
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < 15; i++)
        wreg[i] <= WREG_RESET;
      wreg[STACK_PTR_IDX] <= STACK_PTR_RESET;
    end
    else if (i_x_valid)
    begin
      // Address update first; a data write to the same register overrides it
      if (i_x_mode == MODE_IND_POST)
        wreg[i_x_ptr_sel] <= ptr_val + step;
      else if (is_push)
        wreg[STACK_PTR_IDX] <= wreg[STACK_PTR_IDX] + WORD_STEP;
      else if (is_pop)
        wreg[STACK_PTR_IDX] <= effective_address;
      if (do_write && reg_hit)
      begin
        if (lane_strobe[0])
          wreg[reg_sel[3:0]][7:0] <= lane_wword[7:0];
        if (lane_strobe[1])
          wreg[reg_sel[3:0]][15:8] <= lane_wword[15:8];
      end
      if (do_read && i_dst_en)
      begin
        if (access_byte)
          wreg[i_dst_sel][7:0] <= lane_rdata[7:0];
        else
          wreg[i_dst_sel] <= lane_rdata;
      end
    end
  end

  // ****************************************
  // Stack limit
  // ****************************************
  // Left without reset so software must program it before relying on it
  // Written at the edge, so the very next access already sees the new limit
  always_ff @(posedge i_core_clk)
  begin
    if (do_write && lim_hit)
    begin
      if (lane_strobe[0])
        stack_limit_reg[7:0] <= {lane_wword[7:1], 1'b0};
      if (lane_strobe[1])
        stack_limit_reg[15:8] <= lane_wword[15:8];
    end
    else
      stack_limit_reg[0] <= 1'b0;
  end

  // ****************************************
  // Data memory
  // ****************************************
  logic [9:0] y_idx;

  assign y_idx = ram_index(i_y_addr);

  always_ff @(posedge i_core_clk)
  begin
    if (do_write && mem_hit)
    begin
      if (lane_strobe[0])
        ram[ram_index(effective_address)][7:0] <= lane_wword[7:0];
      if (lane_strobe[1])
        ram[ram_index(effective_address)][15:8] <= lane_wword[15:8];
    end
  end

  // ****************************************
  // X answer
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_x_rvalid <= 1'b0;
      o_x_rdata <= 16'h0000;
      o_x_ea <= 16'h0000;
      o_x_wr_done <= 1'b0;
    end
    else
    begin
      o_x_rvalid <= do_read;
      o_x_wr_done <= do_write;
      if (i_x_valid)
        o_x_ea <= effective_address;
      if (do_read)
        o_x_rdata <= lane_rdata;
    end
  end

  // ****************************************
  // Y answer
  // ****************************************
  // Words only: the low address bit is dropped, no lane select exists
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_y_rvalid <= 1'b0;
      o_y_rdata <= 16'h0000;
    end
    else
    begin
      o_y_rvalid <= i_y_valid;
      if (i_y_valid)
      begin
        if (ram_hit(i_y_addr))
          o_y_rdata <= ram[y_idx];
        else
          o_y_rdata <= 16'h0000;
      end
    end
  end

  // ****************************************
  // Trap requests
  // ****************************************
  logic y_misalign;
  logic addr_err_set;
  logic stack_err_set;

  assign y_misalign = i_y_valid && i_y_addr[0];
  // Y fetches are words only, so an odd Y address is a misaligned word
  assign addr_err_set = (i_x_valid && misalign) || y_misalign;
  // The access still goes ahead; only the trap request reports it
  assign stack_err_set = i_x_valid && stack_err;

  // A new error in the acknowledge cycle keeps the request standing
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_addr_err_req <= 1'b0;
    else if (addr_err_set)
      o_addr_err_req <= 1'b1;
    else if (i_addr_err_ack)
      o_addr_err_req <= 1'b0;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_stack_err_req <= 1'b0;
    else if (stack_err_set)
      o_stack_err_req <= 1'b1;
    else if (i_stack_err_ack)
      o_stack_err_req <= 1'b0;
  end

endmodule

// file: src/dsa_pkg.sv
package dsa_pkg;

  // ****************************************
  // Widths and step sizes
  // ****************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int NEAR_W = 13;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // ****************************************
  // Core register map
  // ****************************************
  localparam logic [15:0] WREG_0_ADDR = 16'h0000;
  localparam logic [15:0] WREG_1_ADDR = 16'h0002;
  localparam logic [15:0] WREG_2_ADDR = 16'h0004;
  localparam logic [15:0] WREG_3_ADDR = 16'h0006;
  localparam logic [15:0] WREG_4_ADDR = 16'h8000;
  localparam logic [15:0] WREG_5_ADDR = 16'h000A;
  localparam logic [15:0] WREG_6_ADDR = 16'h000C;
  localparam logic [15:0] WREG_7_ADDR = 16'h000E;
  localparam logic [15:0] WREG_8_ADDR = 16'h0010;
  localparam logic [15:0] WREG_9_ADDR = 16'h0012;
  localparam logic [15:0] WREG_10_ADDR = 16'h0014;
  localparam logic [15:0] WREG_11_ADDR = 16'h0016;
  localparam logic [15:0] WREG_12_ADDR = 16'h0018;
  localparam logic [15:0] WREG_13_ADDR = 16'h001A;
  localparam logic [15:0] WREG_14_ADDR = 16'h001C;
  localparam logic [15:0] STACK_PTR_ADDR = 16'h001E;
  localparam logic [15:0] STACK_LIM_ADDR = 16'h0020;
  localparam logic [3:0] STACK_PTR_IDX = 4'hF;
  localparam logic [15:0] WREG_RESET = 16'h0000;
  localparam logic [15:0] STACK_PTR_RESET = 16'h0800;

  // ****************************************
  // Data space layout
  // ****************************************
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam logic [15:0] RAM_LAST = 16'h0FFF;
  localparam int RAM_WORDS = 1024;

  typedef enum logic [2:0] {
    MODE_NEAR, MODE_FAR, MODE_IND, MODE_IND_POST, MODE_PUSH, MODE_POP
  } amode_type;

  typedef enum logic [1:0] {PUSH_DATA, PUSH_CALL_HI, PUSH_EXC_HI} push_type;

  // Returns {hit, index} of the working register at a byte address
  function automatic logic [4:0] reg_decode(input logic [15:0] addr);
    logic [15:0] w;
    w = {addr[15:1], 1'b0};
    if (w == WREG_0_ADDR) reg_decode = 5'h10;
    else if (w == WREG_1_ADDR) reg_decode = 5'h11;
    else if (w == WREG_2_ADDR) reg_decode = 5'h12;
    else if (w == WREG_3_ADDR) reg_decode = 5'h13;
    else if (w == WREG_4_ADDR) reg_decode = 5'h14;
    else if (w == WREG_5_ADDR) reg_decode = 5'h15;
    else if (w == WREG_6_ADDR) reg_decode = 5'h16;
    else if (w == WREG_7_ADDR) reg_decode = 5'h17;
    else if (w == WREG_8_ADDR) reg_decode = 5'h18;
    else if (w == WREG_9_ADDR) reg_decode = 5'h19;
    else if (w == WREG_10_ADDR) reg_decode = 5'h1A;
    else if (w == WREG_11_ADDR) reg_decode = 5'h1B;
    else if (w == WREG_12_ADDR) reg_decode = 5'h1C;
    else if (w == WREG_13_ADDR) reg_decode = 5'h1D;
    else if (w == WREG_14_ADDR) reg_decode = 5'h1E;
    else if (w == STACK_PTR_ADDR) reg_decode = 5'h1F;
    else reg_decode = 5'h00;
  endfunction

  function automatic logic ram_hit(input logic [15:0] addr);
    ram_hit = (addr >= RAM_BASE) && (addr <= RAM_LAST);
  endfunction

  function automatic logic [9:0] ram_index(input logic [15:0] addr);
    logic [15:0] off;
    off = addr - RAM_BASE;
    ram_index = off[10:1];
  endfunction

endpackage

// file: src/lane_steer.sv
`timescale 1ns/1ps
module lane_steer
  import dsa_pkg::*;
(
  // Access shape
  input wire logic i_byte,
  input wire logic i_ea_lsb,
  // Data
  input wire logic [15:0] i_word,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic [15:0] o_wword,
  output logic [1:0] o_strobe
);

  always_comb
  begin
    if (i_byte)
    begin
      o_rdata = {8'h00, (i_ea_lsb ? i_word[15:8] : i_word[7:0])};
      o_wword = {i_wdata[7:0], i_wdata[7:0]};
      o_strobe = i_ea_lsb ? 2'h2 : 2'h1;
    end
    else
    begin
      o_rdata = i_word;
      o_wword = i_wdata;
      o_strobe = 2'h3;
    end
  end

endmodule

// file: src/stack_check.sv
`timescale 1ns/1ps
module stack_check
  import dsa_pkg::*;
(
  // Stack address use
  input wire logic i_sp_use,
  input wire logic i_push,
  input wire logic [15:0] i_ea,
  input wire logic [15:0] i_limit,
  // Verdict
  output logic o_err
);

  logic over;
  logic under;

  // Equal to the limit is still a legal push; only beyond it traps
  assign over = i_push && (i_ea > i_limit);
  assign under = i_ea < STACK_FLOOR;
  assign o_err = i_sp_use && (over || under);

endmodule

// file: test/dsa_checker_asserts.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module dsa_checker
  import dsa_pkg::*;
(
  // Clock, reset and requests
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_x_valid,
  input wire logic i_x_write,
  input wire logic i_x_byte,
  input wire amode_type i_x_mode,
  input wire logic [12:0] i_x_near_addr,
  input wire logic [15:0] i_x_far_addr,
  input wire logic i_y_valid,
  input wire logic [15:0] i_y_addr,
  input wire logic i_addr_err_ack,
  input wire logic i_stack_err_ack,
  // Answers
  input wire logic o_x_rvalid,
  input wire logic [15:0] o_x_rdata,
  input wire logic [15:0] o_x_ea,
  input wire logic o_x_wr_done,
  input wire logic o_y_rvalid,
  input wire logic [15:0] o_y_rdata,
  input wire logic o_addr_err_req,
  input wire logic o_stack_err_req
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic rd;
  logic far_w;
  // Push is always a write and pop always a read, whatever the write flag says
  assign rd = i_x_valid && (i_x_mode == MODE_POP || (!i_x_write && i_x_mode != MODE_PUSH));
  assign far_w = i_x_valid && i_x_write && i_x_mode == MODE_FAR && !i_x_byte;
  read_pulse_a: assert property (o_x_rvalid == $past(rd))
    else $error("read answer pulse wrong");
  odd_write_a: assert property (far_w && i_x_far_addr[0] |=> !o_x_wr_done && o_addr_err_req)
    else $error("odd word write not suppressed");
  even_write_a: assert property (far_w && !i_x_far_addr[0] && i_x_far_addr >= RAM_BASE
    && i_x_far_addr <= RAM_LAST |=> o_x_wr_done)
    else $error("aligned write not done");
  far_ea_a: assert property (i_x_valid && i_x_mode == MODE_FAR |=> o_x_ea == $past(i_x_far_addr))
    else $error("far address wrong");
  near_ea_a: assert property (i_x_valid && i_x_mode == MODE_NEAR
    |=> o_x_ea == {3'h0, $past(i_x_near_addr)})
    else $error("near address wrong");
  byte_lane_a: assert property ($past(rd && i_x_byte && i_x_mode != MODE_POP)
    |-> o_x_rdata[15:8] == 8'h00)
    else $error("byte read upper lane not clear");
  y_zero_a: assert property (i_y_valid && i_y_addr > RAM_LAST |=> o_y_rvalid && o_y_rdata == 16'h0000)
    else $error("unimplemented fetch not zero");
  y_odd_a: assert property (i_y_valid && i_y_addr[0] |=> o_addr_err_req)
    else $error("odd word fetch not trapped");
  addr_hold_a: assert property (o_addr_err_req && !i_addr_err_ack |=> o_addr_err_req)
    else $error("address trap dropped early");
  stack_hold_a: assert property (o_stack_err_req && !i_stack_err_ack |=> o_stack_err_req)
    else $error("stack trap dropped early");
  cover property (o_stack_err_req);
  cover property (o_x_wr_done);
  cover property ($rose(o_addr_err_req));
endmodule
bind data_space_access dsa_checker dsa_checker_i (.i_core_clk, .i_rst_n, .i_x_valid, .i_x_write,
  .i_x_byte, .i_x_mode, .i_x_near_addr, .i_x_far_addr, .i_y_valid, .i_y_addr, .i_addr_err_ack,
  .i_stack_err_ack, .o_x_rvalid, .o_x_rdata, .o_x_ea, .o_x_wr_done, .o_y_rvalid, .o_y_rdata,
  .o_addr_err_req, .o_stack_err_req);

// file: test/trap_responder.sv
`timescale 1ns/1ps
// ****
// Exception logic model: acknowledges one trap at a time
// ****
module trap_responder
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Trap side
  input wire logic i_slow,
  input wire logic i_addr_err_req,
  input wire logic i_stack_err_req,
  output logic o_addr_err_ack,
  output logic o_stack_err_ack
);
  logic [3:0] wait_count;
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_count <= 4'h0;
      o_addr_err_ack <= 1'b0;
      o_stack_err_ack <= 1'b0;
    end
    else
    begin
      o_addr_err_ack <= 1'b0;
      o_stack_err_ack <= 1'b0;
      // Request still shows high the cycle after an ack, so restart the count then
      if (!(i_addr_err_req || i_stack_err_req) || o_addr_err_ack || o_stack_err_ack)
        wait_count <= 4'h0;
      else if (wait_count == (i_slow ? 4'h6 : 4'h2))
      begin
        wait_count <= 4'h0;
        o_addr_err_ack <= i_addr_err_req;
        o_stack_err_ack <= !i_addr_err_req;
      end
      else
        wait_count <= wait_count + 4'h1;
    end
  end
endmodule

// file: test/data_space_access_test.sv
`timescale 1ns/1ps
module data_space_access_test
  import dsa_pkg::*;
;
  logic i_core_clk, i_rst_n, i_x_valid, i_x_write, i_x_byte, i_dst_en, i_y_valid, slow;
  amode_type i_x_mode;
  push_type i_push_kind;
  logic [12:0] i_x_near_addr;
  logic [15:0] i_x_far_addr, i_x_wdata, i_y_addr, o_x_rdata, o_x_ea, o_y_rdata;
  logic [3:0] i_x_ptr_sel, i_dst_sel;
  logic [7:0] i_status_low;
  logic i_addr_err_ack, i_stack_err_ack, o_x_rvalid, o_x_wr_done, o_y_rvalid;
  logic o_addr_err_req, o_stack_err_req;
  logic [15:0] regs [13] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h8000, 16'h000A,
    16'h000C, 16'h000E, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018};
  logic [15:0] pops [3] = '{16'h5ACD, 16'h00CD, 16'h1111};
  int bad_count, comparisons;
  data_space_access data_space_access_i (.*);
  trap_responder trap_responder_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_slow(slow),
    .i_addr_err_req(o_addr_err_req), .i_stack_err_req(o_stack_err_req),
    .o_addr_err_ack(i_addr_err_ack), .o_stack_err_ack(i_stack_err_ack));
  always #20 i_core_clk = ~i_core_clk;
  // ****
  // Shared tasks
  // ****
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] g, e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, e);
    chk16({15'h0, g}, {15'h0, e});
  endtask
  task automatic go(input amode_type m, input logic w, b, input logic [15:0] a, d,
    input logic [3:0] p = 4'h0, input logic [4:0] t = 5'h00, input push_type k = PUSH_DATA);
    @(posedge i_core_clk);
    i_x_valid <= 1'b1;
    i_x_mode <= m;
    i_x_write <= w;
    i_x_byte <= b;
    i_x_near_addr <= a[12:0];
    i_x_far_addr <= a;
    i_x_wdata <= d;
    i_x_ptr_sel <= p;
    {i_dst_en, i_dst_sel} <= t;
    i_push_kind <= k;
    @(posedge i_core_clk);
    i_x_valid <= 1'b0;
    #1;
  endtask
  task automatic rdw(input logic [15:0] a, e);
    go(MODE_FAR, 1'b0, 1'b0, a, 16'h0000);
    chk16(o_x_rdata, e);
  endtask
  task automatic yget(input logic [15:0] a);
    @(posedge i_core_clk);
    i_y_valid <= 1'b1;
    i_y_addr <= a;
    @(posedge i_core_clk);
    i_y_valid <= 1'b0;
    #1;
    chk1(o_y_rvalid, 1'b1);
  endtask
  task automatic clear_wait;
    int n;
    n = 0;
    while ((o_addr_err_req !== 1'b0 || o_stack_err_req !== 1'b0) && n < 20)
    begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    chk1(o_addr_err_req | o_stack_err_req, 1'b0);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    foreach (regs[k]) rdw(regs[k], 16'h0000);
    rdw(STACK_PTR_ADDR, 16'h0800);
  endtask
  task automatic t_lanes;
    go(MODE_FAR, 1'b1, 1'b0, 16'h0810, 16'hA5C3);
    go(MODE_FAR, 1'b1, 1'b1, 16'h0811, 16'h007E);
    chk1(o_x_wr_done, 1'b1);
    rdw(16'h0810, 16'h7EC3);
    go(MODE_FAR, 1'b0, 1'b1, 16'h0810, 16'h0000);
    chk16(o_x_rdata, 16'h00C3);
  endtask
  task automatic t_post;
    go(MODE_FAR, 1'b1, 1'b0, 16'h0812, 16'h3C4D);
    go(MODE_FAR, 1'b1, 1'b0, WREG_2_ADDR, 16'h0811);
    go(MODE_FAR, 1'b1, 1'b0, WREG_3_ADDR, 16'hBEEF);
    go(MODE_IND_POST, 1'b0, 1'b1, 16'h0000, 16'h0000, 4'h2, 5'h13);
    chk16(o_x_rdata, 16'h007E);
    rdw(WREG_3_ADDR, 16'hBE7E);
    rdw(WREG_2_ADDR, 16'h0812);
    go(MODE_IND_POST, 1'b0, 1'b0, 16'h0000, 16'h0000, 4'h2, 5'h13);
    chk16(o_x_rdata, 16'h3C4D);
    rdw(WREG_2_ADDR, 16'h0814);
    go(MODE_NEAR, 1'b0, 1'b0, WREG_2_ADDR, 16'h0000);
    chk16(o_x_rdata, 16'h0814);
  endtask
  task automatic t_misalign;
    go(MODE_FAR, 1'b1, 1'b0, 16'h0813, 16'hFFFF);
    chk1(o_x_wr_done, 1'b0);
    chk1(o_addr_err_req, 1'b1);
    clear_wait();
    rdw(16'h0812, 16'h3C4D);
    go(MODE_FAR, 1'b0, 1'b0, 16'h0811, 16'h0000);
    chk1(o_x_rvalid, 1'b1);
    chk1(o_addr_err_req, 1'b1);
    clear_wait();
    yget(16'h0812);
    chk16(o_y_rdata, 16'h3C4D);
    yget(16'h0813);
    chk1(o_addr_err_req, 1'b1);
    clear_wait();
    yget(16'h9000);
    chk16(o_y_rdata, 16'h0000);
    rdw(16'h9000, 16'h0000);
    chk16(o_x_ea, 16'h9000);
  endtask
  task automatic t_stack;
    slow <= 1'b1;
    go(MODE_FAR, 1'b1, 1'b0, STACK_LIM_ADDR, 16'h0803);
    rdw(STACK_LIM_ADDR, 16'h0802);
    go(MODE_PUSH, 1'b1, 1'b0, 16'h0000, 16'h1111);
    chk1(o_x_wr_done, 1'b1);
    go(MODE_PUSH, 1'b1, 1'b0, 16'h0000, 16'hABCD, 4'h0, 5'h00, PUSH_CALL_HI);
    chk1(o_stack_err_req, 1'b0);
    go(MODE_PUSH, 1'b1, 1'b0, 16'h0000, 16'hABCD, 4'h0, 5'h00, PUSH_EXC_HI);
    chk1(o_stack_err_req, 1'b1);
    clear_wait();
    rdw(STACK_PTR_ADDR, 16'h0806);
    rdw(16'h0802, 16'h00CD);
    rdw(16'h0804, 16'h5ACD);
    foreach (pops[k])
    begin
      go(MODE_POP, 1'b0, 1'b0, 16'h0000, 16'h0000, 4'h0, 5'h11);
      chk16(o_x_rdata, pops[k]);
    end
    go(MODE_POP, 1'b0, 1'b0, 16'h0000, 16'h0000);
    chk1(o_stack_err_req, 1'b1);
    clear_wait();
  endtask
  initial
  begin
    repeat (3000) @(posedge i_core_clk);
    bad_count++;
    close_out();
  end
  initial
  begin
    i_core_clk = 1'b0;
    {i_rst_n, i_x_valid, i_x_write, i_x_byte, i_dst_en, i_y_valid, slow} <= 7'h00;
    {i_x_near_addr, i_x_far_addr, i_x_wdata, i_y_addr} <= 61'h0;
    {i_x_ptr_sel, i_dst_sel} <= 8'h00;
    i_x_mode <= MODE_NEAR;
    i_push_kind <= PUSH_DATA;
    i_status_low <= 8'h5A;
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_lanes();
    t_post();
    t_misalign();
    t_stack();
    close_out();
  end
endmodule
